// ===== shared/mmd_regs.vh
// address map constants for the memory map and boot remap decoder
`ifndef MMD_REGS_VH
`define MMD_REGS_VH
// target codes
`define MMD_TGT_NONE     4'h0
`define MMD_TGT_DYN      4'h1
`define MMD_TGT_STAT_HI  4'h2
`define MMD_TGT_STAT_LO  4'h3
`define MMD_TGT_GFX      4'h4
`define MMD_TGT_PERIPH   4'h5
`define MMD_TGT_BRIDGE1  4'h6
`define MMD_TGT_BRIDGE2  4'h7
`define MMD_TGT_ITCM     4'h8
`define MMD_TGT_DTCM     4'h9
// address region bounds
`define MMD_BOOT_LAST    32'h03FFFFFF
`define MMD_DYN_LAST     32'h0FFFFFFF
`define MMD_PER_BASE     32'h10100000
`define MMD_PER_LAST     32'h101FFFFF
`define MMD_STHI_BASE    32'h20000000
`define MMD_STHI_LAST    32'h2FFFFFFF
`define MMD_STLO_BASE    32'h30000000
`define MMD_STLO_LAST    32'h3FFFFFFF
`define MMD_GFX_BASE     32'h40000000
`define MMD_GFX_LAST     32'h40FFFFFF
`define MMD_DYNHI_BASE   32'h70000000
`define MMD_DYNHI_LAST   32'h7FFFFFFF
`define MMD_BR1_BASE     32'h80000000
// tightly coupled ram: 32KB each, one wait state
`define MMD_TCM_BYTES    32'h00008000
`define MMD_TCM_WAIT     2'h1
// peripheral window step, 64KB
`define MMD_PER_SHIFT    16
`endif

// ===== core/mmd_cs_mux.v
// static chip select ownership mux followed by boot remap of the selects
`include "mmd_regs.vh"
module mmd_cs_mux (
    static_owner_select,
    boot_alias_static,
    boot_alias_dynamic,
    boot_alias_external,
    boot_hit,
    smc_cs_n,
    multiport_mem_ctrl_st_cs_n,
    multiport_mem_ctrl_dy_cs_n,
    st_cs_n,
    dy_cs_n,
    boot_off_chip
);
    input  wire       static_owner_select;
    input  wire       boot_alias_static;
    input  wire       boot_alias_dynamic;
    input  wire       boot_alias_external;
    input  wire       boot_hit;
    input  wire [7:0] smc_cs_n;
    input  wire [7:0] multiport_mem_ctrl_st_cs_n;
    input  wire [3:0] multiport_mem_ctrl_dy_cs_n;
    output reg  [7:0] st_cs_n;
    output reg  [3:0] dy_cs_n;
    output wire       boot_off_chip;

    wire [7:0] muxed_st_n;

    // ownership mux comes first
    assign muxed_st_n = static_owner_select ? multiport_mem_ctrl_st_cs_n : smc_cs_n;

    // external alias only when both others are low
    assign boot_off_chip = boot_hit & boot_alias_external & ~boot_alias_static & ~boot_alias_dynamic;

    // remap stage modifies the already muxed lines
    always @* begin
        st_cs_n = muxed_st_n;
        dy_cs_n = multiport_mem_ctrl_dy_cs_n;
        if (boot_hit && boot_alias_static) begin
            if (static_owner_select)
                st_cs_n[1] = 1'b0;
            else
                st_cs_n[7] = 1'b0;
        end else if (boot_hit && boot_alias_dynamic) begin
            dy_cs_n[1] = 1'b0;
        end
    end
endmodule // mmd_cs_mux

// ===== core/mmd_decoder.v
// per-layer address decoder with bridge routing and fault response
`include "mmd_regs.vh"
// Functional notes
// - unmatched addresses go off-chip; bridge map select picks bridge regions.
// - unacknowledged off-chip access ends with an error response.
// - static owner select high gives multiport controller, low static controller.
// - dynamic selects always from multiport controller, unaffected by owner select.
// - ownership mux first, boot remap then modifies chip selects.
// - static alias maps low region to static select 7 or multiport select 1.
// - dynamic alias with static alias low maps low region to dynamic select 1.
// - external alias alone routes low region off-chip.
// - alias covers 0x0 to 0x03FFFFFF, else normal decoding applies.
// - default map sends 0x80000000 and above to bridge one.
// - data master decodes peripheral windows in 64KB steps from 0x10100000.
// - dynamic, static high, static low and graphics regions as mapped.
// - two 32KB tightly coupled rams, one wait state, not reachable by DMA.
// - map select high: upper half bridge one, lower undecoded bridge two.
// - map select low: undecoded data master bridge one, others bridge two below 0x80000000.
module mmd_decoder #(
    parameter TCM_BYTES = 32768
) (
    clock,
    nrst,
    bridge_map_select,
    static_owner_select,
    boot_alias_static,
    boot_alias_dynamic,
    boot_alias_external,
    haddr,
    htrans,
    hready,
    master_is_data,
    master_is_dma,
    itcm_base,
    dtcm_base,
    tcm_enable,
    ext_ack,
    ext_done,
    smc_cs_n,
    multiport_mem_ctrl_st_cs_n,
    multiport_mem_ctrl_dy_cs_n,
    sel_target,
    periph_index,
    st_cs_n,
    dy_cs_n,
    tcm_wait,
    fault_resp,
    hready_out
);
    input  wire       clock;
    input  wire       nrst;
    input  wire       bridge_map_select;
    input  wire       static_owner_select;
    input  wire       boot_alias_static;
    input  wire       boot_alias_dynamic;
    input  wire       boot_alias_external;
    input  wire [31:0] haddr;
    input  wire [1:0] htrans;
    input  wire       hready;
    input  wire       master_is_data;
    input  wire       master_is_dma;
    input  wire [31:0] itcm_base;
    input  wire [31:0] dtcm_base;
    input  wire       tcm_enable;
    input  wire       ext_ack;
    input  wire       ext_done;
    input  wire [7:0] smc_cs_n;
    input  wire [7:0] multiport_mem_ctrl_st_cs_n;
    input  wire [3:0] multiport_mem_ctrl_dy_cs_n;
    output reg  [3:0] sel_target;
    output reg  [3:0] periph_index;
    output wire [7:0] st_cs_n;
    output wire [3:0] dy_cs_n;
    output reg  [1:0] tcm_wait;
    output reg        fault_resp;
    output wire       hready_out;

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_WAIT  = 2'h1;
    localparam [1:0] ST_ERR1  = 2'h2;
    localparam [1:0] ST_ERR2  = 2'h3;

    reg  [3:0]  tgt_d;
    reg  [3:0]  pidx_d;
    reg  [4:0]  cfg_meta_q;
    reg  [4:0]  cfg_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [1:0]  wcnt_q;
    wire        boot_hit;
    wire        boot_off;
    wire        active;
    wire [3:0]  undecoded_tgt;
    wire [31:0] itcm_off;
    wire [31:0] dtcm_off;
    wire        map_sel_s;
    wire        owner_s;
    wire        alias_st_s;
    wire        alias_dy_s;
    wire        alias_ext_s;
    wire        per_win;
    wire        per_hit;
    wire        to_bridge;

    // strap pins come from outside the clock domain: two flops before any use
    // limitation: straps read as low for two cycles after reset
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_meta_q <= 5'h00;
            cfg_q      <= 5'h00;
        end else begin
            cfg_meta_q <= {bridge_map_select, static_owner_select,
                           boot_alias_static, boot_alias_dynamic, boot_alias_external};
            cfg_q      <= cfg_meta_q;
        end
    end

    // only the second flop is read
    assign map_sel_s   = cfg_q[4];
    assign owner_s     = cfg_q[3];
    assign alias_st_s  = cfg_q[2];
    assign alias_dy_s  = cfg_q[1];
    assign alias_ext_s = cfg_q[0];

    assign active   = htrans[1] & hready;
    assign boot_hit = (haddr <= `MMD_BOOT_LAST);
    assign itcm_off = haddr - itcm_base;
    assign dtcm_off = haddr - dtcm_base;

    // windows 5 to C are off-chip; window 0 only while the static controller owns static memory
    assign per_win   = (haddr >= `MMD_PER_BASE) && (haddr <= `MMD_PER_LAST);
    assign per_hit   = per_win && ((haddr[19:16] <= 4'h4) || (haddr[19:16] >= 4'hD)) &&
                       !((haddr[19:16] == 4'h0) && owner_s);
    assign to_bridge = (tgt_d == `MMD_TGT_BRIDGE1) || (tgt_d == `MMD_TGT_BRIDGE2);

    // bridge choice for anything the chip does not claim
    assign undecoded_tgt = map_sel_s ?
        ((haddr >= `MMD_BR1_BASE) ? `MMD_TGT_BRIDGE1 : `MMD_TGT_BRIDGE2) :
        (master_is_data ? `MMD_TGT_BRIDGE1 : `MMD_TGT_BRIDGE2);

    // address phase decode
    always @* begin
        tgt_d  = undecoded_tgt;
        pidx_d = 4'h0;
        if (tcm_enable && !master_is_dma && dtcm_off < TCM_BYTES)
            tgt_d = `MMD_TGT_DTCM;
        else if (tcm_enable && !master_is_dma && itcm_off < TCM_BYTES)
            tgt_d = `MMD_TGT_ITCM;
        else if (boot_hit && (alias_st_s || alias_dy_s)) begin
            // the alias target follows whichever controller owns the static selects
            if (alias_st_s)
                tgt_d = owner_s ? `MMD_TGT_STAT_LO : `MMD_TGT_STAT_HI;
            else
                tgt_d = `MMD_TGT_DYN;
        end else if (boot_off)
            tgt_d = undecoded_tgt;
        else if (haddr >= `MMD_BR1_BASE)
            tgt_d = `MMD_TGT_BRIDGE1;
        else if (haddr <= `MMD_DYN_LAST)
            tgt_d = `MMD_TGT_DYN;
        else if (haddr >= `MMD_DYNHI_BASE && haddr <= `MMD_DYNHI_LAST)
            tgt_d = `MMD_TGT_DYN;
        else if (haddr >= `MMD_STHI_BASE && haddr <= `MMD_STHI_LAST)
            tgt_d = `MMD_TGT_STAT_HI;
        else if (haddr >= `MMD_STLO_BASE && haddr <= `MMD_STLO_LAST)
            tgt_d = `MMD_TGT_STAT_LO;
        else if (master_is_data && haddr >= `MMD_GFX_BASE && haddr <= `MMD_GFX_LAST)
            tgt_d = `MMD_TGT_GFX;
        else if (master_is_data && per_hit) begin
            tgt_d  = `MMD_TGT_PERIPH;
            pidx_d = haddr[19:16];
        end
    end

    // chip select muxing and boot remap in the leaf
    mmd_cs_mux u_cs (
        .static_owner_select (owner_s),
        .boot_alias_static   (alias_st_s),
        .boot_alias_dynamic  (alias_dy_s),
        .boot_alias_external (alias_ext_s),
        .boot_hit            (boot_hit & active),
        .smc_cs_n            (smc_cs_n),
        .multiport_mem_ctrl_st_cs_n        (multiport_mem_ctrl_st_cs_n),
        .multiport_mem_ctrl_dy_cs_n        (multiport_mem_ctrl_dy_cs_n),
        .st_cs_n             (st_cs_n),
        .dy_cs_n             (dy_cs_n),
        .boot_off_chip       (boot_off)
    );

    // two cycle error response per bus protocol
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // a phase stalled behind a tcm wait is not taken yet
                if (active && hready_out && to_bridge)
                    state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (ext_done)
                    state_d = ext_ack ? ST_IDLE : ST_ERR1;
            end
            ST_ERR1: state_d = ST_ERR2;
            ST_ERR2: begin
                // ready is high here, so a new phase may be taken
                if (active && to_bridge)
                    state_d = ST_WAIT;
                else
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // target latched in address phase, held through data phase
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_target   <= `MMD_TGT_NONE;
            periph_index <= 4'h0;
            state_q      <= ST_IDLE;
            wcnt_q       <= 2'h0;
            tcm_wait     <= 2'h0;
            fault_resp   <= 1'b0;
        end else begin
            state_q    <= state_d;
            fault_resp <= (state_d == ST_ERR1) || (state_d == ST_ERR2);
            if (hready_out) begin
                sel_target   <= active ? tgt_d : `MMD_TGT_NONE;
                periph_index <= active ? pidx_d : 4'h0;
                if (active && (tgt_d == `MMD_TGT_ITCM || tgt_d == `MMD_TGT_DTCM))
                    wcnt_q <= `MMD_TCM_WAIT;
                else
                    wcnt_q <= 2'h0;
            end else if (wcnt_q != 2'h0)
                wcnt_q <= wcnt_q - 2'h1;
            tcm_wait <= wcnt_q;
        end
    end

    // wait states stall the layer until the data phase can finish
    assign hready_out = (wcnt_q == 2'h0) && (state_q != ST_WAIT) && (state_q != ST_ERR1);
endmodule // mmd_decoder

// ===== bench/mmd_monitor.sv
// concurrent checks on the decoder ports
`include "mmd_regs.vh"
module mmd_monitor (
    input logic        clock,
    input logic        nrst,
    input logic        bridge_map_select,
    input logic        boot_alias_dynamic,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hready,
    input logic        master_is_data,
    input logic [3:0]  multiport_mem_ctrl_dy_cs_n,
    input logic [3:0]  sel_target,
    input logic [3:0]  dy_cs_n,
    input logic        fault_resp,
    input logic        hready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // taken phase and the two bridge cases
    wire tk = htrans[1] && hready && hready_out;
    wire br = sel_target[3:1] == 3'h3;
    wire hi = tk && bridge_map_select && haddr[31];
    wire mid = tk && haddr[31:28] == 4'h6;
    a_hold_target: assert property (!hready_out |=> $stable(sel_target)) else $error("target moved");
    a_upper_bridge: assert property (hi |=> sel_target == `MMD_TGT_BRIDGE1) else $error("upper");
    a_bridge_stall: assert property (hi |=> !hready_out) else $error("no stall");
    a_lower_bridge: assert property (mid && bridge_map_select |=> sel_target == `MMD_TGT_BRIDGE2) else $error("lower");
    a_data_bridge: assert property (mid && !bridge_map_select && master_is_data |=> sel_target == `MMD_TGT_BRIDGE1)
        else $error("data map");
    a_dyn_owner: assert property (!boot_alias_dynamic |-> dy_cs_n == multiport_mem_ctrl_dy_cs_n) else $error("dyn sel");
    a_fault_width: assert property ($rose(fault_resp) |=> fault_resp ##1 !fault_resp) else $error("fault len");
    a_fault_source: assert property (fault_resp |-> br) else $error("fault src");
    // main scenarios reached
    c_upper: cover property (hi);
    c_fault: cover property ($rose(fault_resp));
    c_data_low: cover property (mid && !bridge_map_select);
endmodule // mmd_monitor
bind mmd_decoder mmd_monitor u_mon (
    .clock              (clock),
    .nrst               (nrst),
    .bridge_map_select  (bridge_map_select),
    .boot_alias_dynamic (boot_alias_dynamic),
    .haddr              (haddr),
    .htrans             (htrans),
    .hready             (hready),
    .master_is_data     (master_is_data),
    .multiport_mem_ctrl_dy_cs_n       (multiport_mem_ctrl_dy_cs_n),
    .sel_target         (sel_target),
    .dy_cs_n            (dy_cs_n),
    .fault_resp         (fault_resp),
    .hready_out         (hready_out)
);

// ===== bench/mmd_bridge_model.sv
// off-chip bridge: answers after 3 or 7 cycles
module mmd_bridge_model (
    input  logic clock,
    input  logic nrst,
    input  logic pending,
    input  logic ack_en,
    input  logic slow,
    output logic ext_ack,
    output logic ext_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt_q;
    wire        fire = pending && cnt_q == (slow ? 3'h6 : 3'h2);
    // restart after each reply; ack wanders while no reply stands
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {cnt_q, ext_done, ext_ack} <= 5'h0;
        end else begin
            ext_done <= fire;
            ext_ack <= fire ? ack_en : !ext_ack;
            cnt_q <= (pending && !ext_done) ? cnt_q + 3'h1 : 3'h0;
        end
    end
endmodule // mmd_bridge_model

// ===== bench/mmd_decoder_tb_top.sv
// self-checking bench for the memory map decoder
`include "mmd_regs.vh"
module mmd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'h0, nrst = 1'h0, hready = 1'h1, tcm_enable = 1'h0, master_is_dma = 1'h0;
    logic        ack_en = 1'h1, slow = 1'h0, master_is_data = 1'h1, bridge_map_select = 1'h1;
    logic        static_owner_select = 1'h0, saw_fault, ext_ack, ext_done, fault_resp, hready_out;
    logic [2:0]  boot_mode = 3'h0;
    logic [1:0]  htrans = 2'h0, tcm_wait;
    logic [31:0] haddr = 32'h0, itcm_base = 32'h58000000, dtcm_base = 32'h50000000;
    logic [7:0]  smc_cs_n = 8'hFF, multiport_mem_ctrl_st_cs_n = 8'hAF, st_cs_n, ap_st;
    logic [3:0]  multiport_mem_ctrl_dy_cs_n = 4'h6, sel_target, periph_index, dy_cs_n, ap_dy;
    int          error_cnt = 0, total_checks = 0, waits;
    mmd_decoder dut (
        .clock               (clock),
        .nrst                (nrst),
        .bridge_map_select   (bridge_map_select),
        .static_owner_select (static_owner_select),
        .boot_alias_static   (boot_mode[2]),
        .boot_alias_dynamic  (boot_mode[1]),
        .boot_alias_external (boot_mode[0]),
        .haddr               (haddr),
        .htrans              (htrans),
        .hready              (hready),
        .master_is_data      (master_is_data),
        .master_is_dma       (master_is_dma),
        .itcm_base           (itcm_base),
        .dtcm_base           (dtcm_base),
        .tcm_enable          (tcm_enable),
        .ext_ack             (ext_ack),
        .ext_done            (ext_done),
        .smc_cs_n            (smc_cs_n),
        .multiport_mem_ctrl_st_cs_n        (multiport_mem_ctrl_st_cs_n),
        .multiport_mem_ctrl_dy_cs_n        (multiport_mem_ctrl_dy_cs_n),
        .sel_target          (sel_target),
        .periph_index        (periph_index),
        .st_cs_n             (st_cs_n),
        .dy_cs_n             (dy_cs_n),
        .tcm_wait            (tcm_wait),
        .fault_resp          (fault_resp),
        .hready_out          (hready_out)
    );
    mmd_bridge_model far (.clock, .nrst, .pending(!hready_out && sel_target[3:1] == 3'h3),
        .ack_en, .slow, .ext_ack, .ext_done);
    initial forever #2 clock = ~clock;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) error_cnt++;
        if (got !== exp) $display("[ERR] %0t got %h expected %h", $time, got, exp);
    endtask
    // two idle edges let strap changes pass the synchroniser, then one address phase
    task acc(input logic [31:0] a, input logic [3:0] tgt);
        repeat (2) @(posedge clock);
        #1 {haddr, htrans} = {a, 2'h2};
        #1 {ap_st, ap_dy} = {st_cs_n, dy_cs_n};
        @(posedge clock);
        #1 htrans = 2'h0;
        waits = 0;
        saw_fault = fault_resp;
        while (hready_out !== 1'h1 && waits < 50) begin
            @(posedge clock);
            #1 waits++;
            saw_fault |= fault_resp;
        end
        chk({4'h0, sel_target}, {4'h0, tgt});
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // about 110 cycles of work, so 5000 means a hang
    initial begin
        #20000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge clock);
        #1 nrst = 1'h1;
        acc(32'h80000000, `MMD_TGT_BRIDGE1);
        chk({7'h0, saw_fault}, 8'h0);
        acc(32'h6FFFFFFC, `MMD_TGT_BRIDGE2);
        acc(32'h0FFFFFFC, `MMD_TGT_DYN);
        acc(32'h2FFFFFFC, `MMD_TGT_STAT_HI);
        acc(32'h30000000, `MMD_TGT_STAT_LO);
        acc(32'h40FFFFFC, `MMD_TGT_GFX);
        acc(32'h10150000, `MMD_TGT_BRIDGE2);
        acc(32'h10110000, `MMD_TGT_PERIPH);
        chk({4'h0, periph_index}, 8'h1);
        acc(32'h101FFFFC, `MMD_TGT_PERIPH);
        chk({4'h0, periph_index}, 8'hF);
        {slow, ack_en} = 2'h2;
        acc(32'h90000000, `MMD_TGT_BRIDGE1);
        chk({7'h0, saw_fault}, 8'h1);
        {slow, ack_en, bridge_map_select} = 3'h2;
        acc(32'h60000000, `MMD_TGT_BRIDGE1);
        master_is_data = 1'h0;
        acc(32'h60000000, `MMD_TGT_BRIDGE2);
        {bridge_map_select, tcm_enable} = 2'h3;
        acc(itcm_base, `MMD_TGT_ITCM);
        chk({6'h0, tcm_wait}, {6'h0, `MMD_TCM_WAIT});
        master_is_dma = 1'h1;
        acc(dtcm_base, `MMD_TGT_BRIDGE2);
        {master_is_dma, master_is_data} = 2'h1;
        acc(dtcm_base + 32'h7FFC, `MMD_TGT_DTCM);
        chk(waits[7:0], 8'h1);
        for (int o = 0; o < 2; o++) begin
            @(posedge clock);
            #1 static_owner_select = o[0];
            repeat (2) @(posedge clock);
            #1 chk(st_cs_n, o ? 8'hAF : 8'hFF);
            chk({4'h0, dy_cs_n}, 8'h6);
        end
        {boot_mode, static_owner_select} = 4'h8;
        acc(32'h00000100, `MMD_TGT_STAT_HI);
        chk(ap_st, 8'h7F);
        acc(32'h04000000, `MMD_TGT_DYN);
        chk(ap_st, 8'hFF);
        static_owner_select = 1'h1;
        acc(32'h00000100, `MMD_TGT_STAT_LO);
        chk(ap_st, 8'hAD);
        boot_mode = 3'h2;
        acc(32'h00000100, `MMD_TGT_DYN);
        chk({4'h0, ap_dy}, 8'h4);
        chk(ap_st, 8'hAF);
        boot_mode = 3'h1;
        acc(32'h00000100, `MMD_TGT_BRIDGE2);
        chk({4'h0, ap_dy}, 8'h6);
        chk(ap_st, 8'hAF);
        wrap_up;
    end
endmodule // mmd_decoder_tb_top
